// >>> core/adm_pkg.sv
// Purpose: Shared constants and types for the aux/mult instruction decoder
// Assumes: 16-bit instruction words, one word per fetch handshake
// Notes: Opcode patterns are kept at the width of the bits they compare
package adm_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 7;

  // Operation classes on the decoded output
  typedef enum logic [5:0] {
    ADM_OP_NONE = 6'h00,
    ADM_OP_MINUS_MULT_SHIFT = 6'h01,
    ADM_OP_XOR_MEM = 6'h02,
    ADM_OP_XOR_IMM = 6'h03,
    ADM_OP_CLEAR_ACC = 6'h04,
    ADM_OP_CLR_LOAD_UPPER = 6'h05,
    ADM_OP_CLR_LOAD_UPPER_RND = 6'h06,
    ADM_OP_CLR_LOAD_LOWER_U = 6'h07,
    ADM_OP_AUX_ADD_SHORT = 6'h08,
    ADM_OP_AUX_COMPARE = 6'h09,
    ADM_OP_AUX_LOAD = 6'h0a,
    ADM_OP_AUX_LOAD_SHORT = 6'h0b,
    ADM_OP_AUX_PTR_LOAD = 6'h0c,
    ADM_OP_PAGE_LOAD = 6'h0d,
    ADM_OP_PAGE_LOAD_SHORT = 6'h0e,
    ADM_OP_AUX_LOAD_LONG = 6'h0f,
    ADM_OP_AUX_MODIFY = 6'h10,
    ADM_OP_AUX_STORE = 6'h11,
    ADM_OP_PRODUCT_ADD = 6'h12,
    ADM_OP_PRODUCT_HIGH_LOAD = 6'h13,
    ADM_OP_FACTOR_LOAD = 6'h14,
    ADM_OP_FACTOR_LOAD_ACC = 6'h15,
    ADM_OP_FACTOR_LOAD_ACC_MOVE = 6'h16,
    ADM_OP_FACTOR_LOAD_PROD_MOVE = 6'h17,
    ADM_OP_FACTOR_LOAD_SUB = 6'h18,
    ADM_OP_MAC_PROG = 6'h19,
    ADM_OP_MAC_SHIFT_DATA = 6'h1a,
    ADM_OP_PRODUCT_OF_FACTOR = 6'h1b,
    ADM_OP_PRODUCT_AND_ACC = 6'h1c,
    ADM_OP_PRODUCT_BY_IMM = 6'h1d,
    ADM_OP_PRODUCT_AND_SUB = 6'h1e,
    ADM_OP_PRODUCT_UNSIGNED = 6'h1f,
    ADM_OP_PRODUCT_TO_ACC = 6'h20,
    ADM_OP_PRODUCT_SUB_ACC = 6'h21,
    ADM_OP_PRODUCT_HIGH_STORE = 6'h22,
    ADM_OP_PRODUCT_LOW_STORE = 6'h23,
    ADM_OP_PRODUCT_SHIFT_SET = 6'h24,
    ADM_OP_SQUARE_ACC = 6'h25,
    ADM_OP_SQUARE_SUB = 6'h26
  } adm_op_e;

  // Top-byte opcodes of direct/indirect memory-reference words
  localparam logic [7:0] OPC_MINUS_MULT_SHIFT = 8'h46;
  localparam logic [7:0] OPC_XOR_MEM = 8'h4c;
  localparam logic [7:0] OPC_CLR_LOAD_UPPER = 8'h40;
  localparam logic [7:0] OPC_CLR_LOAD_UPPER_RND = 8'h7b;
  localparam logic [7:0] OPC_CLR_LOAD_LOWER_U = 8'h41;
  localparam logic [7:0] OPC_AUX_ADD_SHORT = 8'h7e;
  localparam logic [7:0] OPC_AUX_MODIFY = 8'h55;
  localparam logic [7:0] OPC_PAGE_LOAD = 8'h52;
  localparam logic [7:0] OPC_PRODUCT_HIGH_LOAD = 8'h53;
  localparam logic [7:0] OPC_PRODUCT_HIGH_STORE = 8'h7d;
  localparam logic [7:0] OPC_PRODUCT_LOW_STORE = 8'h7c;
  localparam logic [7:0] OPC_FACTOR_LOAD = 8'h3c;
  localparam logic [7:0] OPC_FACTOR_LOAD_ACC = 8'h3d;
  localparam logic [7:0] OPC_FACTOR_LOAD_ACC_MOVE = 8'h3f;
  localparam logic [7:0] OPC_FACTOR_LOAD_PROD_MOVE = 8'h3e;
  localparam logic [7:0] OPC_FACTOR_LOAD_SUB = 8'h5b;
  localparam logic [7:0] OPC_MAC_PROG = 8'h5d;
  localparam logic [7:0] OPC_MAC_SHIFT_DATA = 8'h5c;
  localparam logic [7:0] OPC_PRODUCT_OF_FACTOR = 8'h38;
  localparam logic [7:0] OPC_PRODUCT_AND_ACC = 8'h3a;
  localparam logic [7:0] OPC_PRODUCT_AND_SUB = 8'h3b;
  localparam logic [7:0] OPC_PRODUCT_UNSIGNED = 8'hcf;
  localparam logic [7:0] OPC_SQUARE_ACC = 8'h39;
  localparam logic [7:0] OPC_SQUARE_SUB = 8'h5a;

  // Prefixes on bits 15-11 with a register index in bits 10-8
  localparam logic [4:0] PFX_AUX_LOAD = 5'h06;
  localparam logic [4:0] PFX_AUX_STORE = 5'h0e;
  localparam logic [4:0] PFX_AUX_LOAD_SHORT = 5'h18;
  localparam logic [4:0] PFX_AUX_LOAD_LONG = 5'h1a;
  localparam logic [7:0] LOW_AUX_LOAD_LONG = 8'h00;

  // Shifted-immediate XOR: top nibble, shift in 11-8, fixed low byte
  localparam logic [3:0] PFX_XOR_IMM = 4'hd;
  localparam logic [7:0] LOW_XOR_IMM = 8'h06;

  // Other prefixes and full words
  localparam logic [6:0] PFX_PAGE_LOAD_SHORT = 7'h64;
  localparam logic [2:0] PFX_PRODUCT_BY_IMM = 3'h5;
  localparam logic [12:0] PFX_AUX_PTR_LOAD = 13'h0ab1;
  localparam logic [13:0] PFX_AUX_COMPARE = 14'h3394;
  localparam logic [13:0] PFX_PRODUCT_SHIFT_SET = 14'h3382;
  localparam logic [15:0] WORD_CLEAR_ACC = 16'hca00;
  localparam logic [15:0] WORD_PRODUCT_ADD = 16'hce15;
  localparam logic [15:0] WORD_PRODUCT_TO_ACC = 16'hce14;
  localparam logic [15:0] WORD_PRODUCT_SUB_ACC = 16'hce16;

  // Program counter steps
  localparam logic [1:0] PC_STEP_ONE = 2'h1;
  localparam logic [1:0] PC_STEP_TWO = 2'h2;
endpackage : adm_pkg

// >>> core/adm_match.sv
// Purpose: Pure combinational classifier of one instruction word
// Assumes: First word of an instruction only
// Notes: Unmatched words give ADM_OP_NONE and no length claim
`timescale 1ns/1ps
`default_nettype none
module adm_match (
  input wire logic [15:0] word,
  output adm_pkg::adm_op_e op,
  output logic two_word,
  output logic hit
);
  always_comb begin
    op = adm_pkg::ADM_OP_NONE;
    two_word = 1'b0;
    // Full-word and long-prefix matches first: the pointer-load prefix sits inside OPC_AUX_MODIFY
    if (word == adm_pkg::WORD_CLEAR_ACC) begin
      op = adm_pkg::ADM_OP_CLEAR_ACC;
    end else if (word == adm_pkg::WORD_PRODUCT_ADD) begin
      op = adm_pkg::ADM_OP_PRODUCT_ADD;
    end else if (word == adm_pkg::WORD_PRODUCT_TO_ACC) begin
      op = adm_pkg::ADM_OP_PRODUCT_TO_ACC;
    end else if (word == adm_pkg::WORD_PRODUCT_SUB_ACC) begin
      op = adm_pkg::ADM_OP_PRODUCT_SUB_ACC;
    end else if (word[15:2] == adm_pkg::PFX_AUX_COMPARE) begin
      op = adm_pkg::ADM_OP_AUX_COMPARE;
    end else if (word[15:2] == adm_pkg::PFX_PRODUCT_SHIFT_SET) begin
      op = adm_pkg::ADM_OP_PRODUCT_SHIFT_SET;
    end else if (word[15:3] == adm_pkg::PFX_AUX_PTR_LOAD) begin
      op = adm_pkg::ADM_OP_AUX_PTR_LOAD;
    end else if (word[15:12] == adm_pkg::PFX_XOR_IMM &&
                 word[7:0] == adm_pkg::LOW_XOR_IMM) begin
      op = adm_pkg::ADM_OP_XOR_IMM;
      two_word = 1'b1;
    end else if (word[15:11] == adm_pkg::PFX_AUX_LOAD_LONG &&
                 word[7:0] == adm_pkg::LOW_AUX_LOAD_LONG) begin
      op = adm_pkg::ADM_OP_AUX_LOAD_LONG;
      two_word = 1'b1;
    end else if (word[15:9] == adm_pkg::PFX_PAGE_LOAD_SHORT) begin
      op = adm_pkg::ADM_OP_PAGE_LOAD_SHORT;
    end else if (word[15:13] == adm_pkg::PFX_PRODUCT_BY_IMM) begin
      op = adm_pkg::ADM_OP_PRODUCT_BY_IMM;
    end else if (word[15:11] == adm_pkg::PFX_AUX_LOAD) begin
      op = adm_pkg::ADM_OP_AUX_LOAD;
    end else if (word[15:11] == adm_pkg::PFX_AUX_STORE) begin
      op = adm_pkg::ADM_OP_AUX_STORE;
    end else if (word[15:11] == adm_pkg::PFX_AUX_LOAD_SHORT) begin
      op = adm_pkg::ADM_OP_AUX_LOAD_SHORT;
    end else begin
      case (word[15:8])
        adm_pkg::OPC_MINUS_MULT_SHIFT: op = adm_pkg::ADM_OP_MINUS_MULT_SHIFT;
        adm_pkg::OPC_XOR_MEM: op = adm_pkg::ADM_OP_XOR_MEM;
        adm_pkg::OPC_CLR_LOAD_UPPER: op = adm_pkg::ADM_OP_CLR_LOAD_UPPER;
        adm_pkg::OPC_CLR_LOAD_UPPER_RND: op = adm_pkg::ADM_OP_CLR_LOAD_UPPER_RND;
        adm_pkg::OPC_CLR_LOAD_LOWER_U: op = adm_pkg::ADM_OP_CLR_LOAD_LOWER_U;
        adm_pkg::OPC_AUX_ADD_SHORT: op = adm_pkg::ADM_OP_AUX_ADD_SHORT;
        adm_pkg::OPC_AUX_MODIFY: op = adm_pkg::ADM_OP_AUX_MODIFY;
        adm_pkg::OPC_PAGE_LOAD: op = adm_pkg::ADM_OP_PAGE_LOAD;
        adm_pkg::OPC_PRODUCT_HIGH_LOAD: op = adm_pkg::ADM_OP_PRODUCT_HIGH_LOAD;
        adm_pkg::OPC_PRODUCT_HIGH_STORE: op = adm_pkg::ADM_OP_PRODUCT_HIGH_STORE;
        adm_pkg::OPC_PRODUCT_LOW_STORE: op = adm_pkg::ADM_OP_PRODUCT_LOW_STORE;
        adm_pkg::OPC_FACTOR_LOAD: op = adm_pkg::ADM_OP_FACTOR_LOAD;
        adm_pkg::OPC_FACTOR_LOAD_ACC: op = adm_pkg::ADM_OP_FACTOR_LOAD_ACC;
        adm_pkg::OPC_FACTOR_LOAD_ACC_MOVE: op = adm_pkg::ADM_OP_FACTOR_LOAD_ACC_MOVE;
        adm_pkg::OPC_FACTOR_LOAD_PROD_MOVE: op = adm_pkg::ADM_OP_FACTOR_LOAD_PROD_MOVE;
        adm_pkg::OPC_FACTOR_LOAD_SUB: op = adm_pkg::ADM_OP_FACTOR_LOAD_SUB;
        adm_pkg::OPC_MAC_PROG: begin
          op = adm_pkg::ADM_OP_MAC_PROG;
          two_word = 1'b1;
        end
        adm_pkg::OPC_MAC_SHIFT_DATA: begin
          op = adm_pkg::ADM_OP_MAC_SHIFT_DATA;
          two_word = 1'b1;
        end
        adm_pkg::OPC_PRODUCT_OF_FACTOR: op = adm_pkg::ADM_OP_PRODUCT_OF_FACTOR;
        adm_pkg::OPC_PRODUCT_AND_ACC: op = adm_pkg::ADM_OP_PRODUCT_AND_ACC;
        adm_pkg::OPC_PRODUCT_AND_SUB: op = adm_pkg::ADM_OP_PRODUCT_AND_SUB;
        adm_pkg::OPC_PRODUCT_UNSIGNED: op = adm_pkg::ADM_OP_PRODUCT_UNSIGNED;
        adm_pkg::OPC_SQUARE_ACC: op = adm_pkg::ADM_OP_SQUARE_ACC;
        adm_pkg::OPC_SQUARE_SUB: op = adm_pkg::ADM_OP_SQUARE_SUB;
        default: op = adm_pkg::ADM_OP_NONE;
      endcase
    end
    hit = (op != adm_pkg::ADM_OP_NONE);
  end
endmodule : adm_match
`default_nettype wire

// >>> core/adm_ctl.sv
// Purpose: Maps an operation class to per-unit datapath strobes
// Assumes: Class already qualified by the sequencer
// Notes: One strobe set per class; the datapath owns the arithmetic
`timescale 1ns/1ps
`default_nettype none
module adm_ctl (
  input wire adm_pkg::adm_op_e op,
  output logic acc_clear,
  output logic acc_load_high,
  output logic acc_load_low_u,
  output logic acc_round,
  output logic acc_add_p,
  output logic acc_sub_p,
  output logic acc_load_p,
  output logic acc_xor,
  output logic t_load,
  output logic mult_start,
  output logic mult_unsigned,
  output logic data_move
);
  always_comb begin
    acc_clear = 1'b0;
    acc_load_high = 1'b0;
    acc_load_low_u = 1'b0;
    acc_round = 1'b0;
    acc_add_p = 1'b0;
    acc_sub_p = 1'b0;
    acc_load_p = 1'b0;
    acc_xor = 1'b0;
    t_load = 1'b0;
    mult_start = 1'b0;
    mult_unsigned = 1'b0;
    data_move = 1'b0;
    case (op)
      adm_pkg::ADM_OP_CLEAR_ACC: acc_clear = 1'b1;
      adm_pkg::ADM_OP_CLR_LOAD_UPPER: begin
        acc_clear = 1'b1;
        acc_load_high = 1'b1;
      end
      adm_pkg::ADM_OP_CLR_LOAD_UPPER_RND: begin
        acc_clear = 1'b1;
        acc_load_high = 1'b1;
        acc_round = 1'b1;
      end
      adm_pkg::ADM_OP_CLR_LOAD_LOWER_U: begin
        acc_clear = 1'b1;
        acc_load_low_u = 1'b1;
      end
      adm_pkg::ADM_OP_XOR_MEM, adm_pkg::ADM_OP_XOR_IMM: acc_xor = 1'b1;
      adm_pkg::ADM_OP_PRODUCT_ADD: acc_add_p = 1'b1;
      adm_pkg::ADM_OP_PRODUCT_TO_ACC: acc_load_p = 1'b1;
      adm_pkg::ADM_OP_PRODUCT_SUB_ACC: acc_sub_p = 1'b1;
      adm_pkg::ADM_OP_FACTOR_LOAD: t_load = 1'b1;
      adm_pkg::ADM_OP_FACTOR_LOAD_ACC: begin
        t_load = 1'b1;
        acc_add_p = 1'b1;
      end
      adm_pkg::ADM_OP_FACTOR_LOAD_ACC_MOVE: begin
        t_load = 1'b1;
        acc_add_p = 1'b1;
        data_move = 1'b1;
      end
      adm_pkg::ADM_OP_FACTOR_LOAD_PROD_MOVE: begin
        t_load = 1'b1;
        acc_load_p = 1'b1;
      end
      adm_pkg::ADM_OP_FACTOR_LOAD_SUB: begin
        t_load = 1'b1;
        acc_sub_p = 1'b1;
      end
      adm_pkg::ADM_OP_MAC_PROG: begin
        acc_add_p = 1'b1;
        mult_start = 1'b1;
      end
      adm_pkg::ADM_OP_MAC_SHIFT_DATA: begin
        acc_add_p = 1'b1;
        mult_start = 1'b1;
        data_move = 1'b1;
      end
      adm_pkg::ADM_OP_PRODUCT_OF_FACTOR,
      adm_pkg::ADM_OP_PRODUCT_BY_IMM: mult_start = 1'b1;
      adm_pkg::ADM_OP_PRODUCT_AND_ACC: begin
        mult_start = 1'b1;
        acc_add_p = 1'b1;
      end
      adm_pkg::ADM_OP_PRODUCT_AND_SUB: begin
        mult_start = 1'b1;
        acc_sub_p = 1'b1;
      end
      adm_pkg::ADM_OP_PRODUCT_UNSIGNED: begin
        mult_start = 1'b1;
        mult_unsigned = 1'b1;
      end
      adm_pkg::ADM_OP_SQUARE_ACC: begin
        t_load = 1'b1;
        mult_start = 1'b1;
        acc_add_p = 1'b1;
      end
      adm_pkg::ADM_OP_SQUARE_SUB: begin
        t_load = 1'b1;
        mult_start = 1'b1;
        acc_sub_p = 1'b1;
      end
      default: acc_clear = 1'b0;
    endcase
  end
endmodule : adm_ctl
`default_nettype wire

// >>> core/adm_decoder.sv
// Purpose: Decoder for accumulator-memory, aux/page and multiplier groups
// Assumes: Fetch stage offers one word per in_valid & in_ready
// Notes: Unmatched first words are forwarded, never acted on here
`timescale 1ns/1ps
`default_nettype none
module adm_decoder (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [15:0] in_word,
  input wire logic in_valid,
  output logic in_ready,
  output logic dec_valid,
  output adm_pkg::adm_op_e dec_op,
  output logic [15:0] dec_word,
  output logic [15:0] dec_imm,
  output logic dec_indirect,
  output logic [6:0] dec_addr,
  output logic [2:0] dec_aux_idx,
  output logic [1:0] dec_mode,
  output logic [3:0] dec_shift,
  output logic [8:0] dec_page,
  output logic [1:0] dec_pc_step,
  output logic acc_clear,
  output logic acc_load_high,
  output logic acc_load_low_u,
  output logic acc_round,
  output logic acc_add_p,
  output logic acc_sub_p,
  output logic acc_load_p,
  output logic acc_xor,
  output logic t_load,
  output logic mult_start,
  output logic mult_unsigned,
  output logic data_move,
  output logic fwd_valid,
  output logic [15:0] fwd_word
);
  typedef enum logic [1:0] {
    ADM_ST_FIRST = 2'b01,
    ADM_ST_SECOND = 2'b10
  } adm_state_e;

  adm_state_e state_r, state_nxt;
  adm_pkg::adm_op_e hit_op, hold_op_r, hold_op_nxt, out_op_r, out_op_nxt;
  logic hit, hit_two;
  logic [15:0] hold_word_r, hold_word_nxt;
  logic [15:0] word_r, word_nxt, imm_r, imm_nxt, fwd_r, fwd_nxt;
  logic [1:0] step_r, step_nxt;
  logic valid_r, valid_nxt, fwd_v_r, fwd_v_nxt;

  adm_match u_match (
    .word(in_word),
    .op(hit_op),
    .two_word(hit_two),
    .hit(hit)
  );

  // Sign-extend the 13-bit multiply immediate
  function automatic logic [15:0] imm_of(input adm_pkg::adm_op_e op,
                                         input logic [15:0] w);
    case (op)
      adm_pkg::ADM_OP_PRODUCT_BY_IMM: imm_of = {{3{w[12]}}, w[12:0]};
      adm_pkg::ADM_OP_AUX_ADD_SHORT,
      adm_pkg::ADM_OP_AUX_LOAD_SHORT: imm_of = {8'h00, w[7:0]};
      default: imm_of = 16'h0000;
    endcase
  endfunction : imm_of

  assign in_ready = 1'b1;

  always_comb begin
    state_nxt = state_r;
    hold_op_nxt = hold_op_r;
    hold_word_nxt = hold_word_r;
    out_op_nxt = out_op_r;
    word_nxt = word_r;
    imm_nxt = imm_r;
    step_nxt = step_r;
    valid_nxt = 1'b0;
    fwd_v_nxt = 1'b0;
    fwd_nxt = fwd_r;
    if (in_valid) begin
      case (state_r)
        ADM_ST_FIRST: begin
          if (hit && hit_two) begin
            // Hold the first word; nothing issues until the operand arrives
            hold_op_nxt = hit_op;
            hold_word_nxt = in_word;
            state_nxt = ADM_ST_SECOND;
          end else if (hit) begin
            valid_nxt = 1'b1;
            out_op_nxt = hit_op;
            word_nxt = in_word;
            imm_nxt = imm_of(hit_op, in_word);
            step_nxt = adm_pkg::PC_STEP_ONE;
          end else begin
            fwd_v_nxt = 1'b1;
            fwd_nxt = in_word;
          end
        end
        ADM_ST_SECOND: begin
          valid_nxt = 1'b1;
          out_op_nxt = hold_op_r;
          word_nxt = hold_word_r;
          imm_nxt = in_word;
          step_nxt = adm_pkg::PC_STEP_TWO;
          state_nxt = ADM_ST_FIRST;
        end
        default: state_nxt = ADM_ST_FIRST;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_r <= ADM_ST_FIRST;
      hold_op_r <= adm_pkg::ADM_OP_NONE;
      hold_word_r <= 16'h0000;
      out_op_r <= adm_pkg::ADM_OP_NONE;
      word_r <= 16'h0000;
      imm_r <= 16'h0000;
      step_r <= 2'h0;
      valid_r <= 1'b0;
      fwd_v_r <= 1'b0;
      fwd_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      hold_op_r <= hold_op_nxt;
      hold_word_r <= hold_word_nxt;
      out_op_r <= out_op_nxt;
      word_r <= word_nxt;
      imm_r <= imm_nxt;
      step_r <= step_nxt;
      valid_r <= valid_nxt;
      fwd_v_r <= fwd_v_nxt;
      fwd_r <= fwd_nxt;
    end
  end

  // Strobes only while a decode is presented; fields stand until the next
  adm_ctl u_ctl (
    .op(valid_r ? out_op_r : adm_pkg::ADM_OP_NONE),
    .acc_clear(acc_clear),
    .acc_load_high(acc_load_high),
    .acc_load_low_u(acc_load_low_u),
    .acc_round(acc_round),
    .acc_add_p(acc_add_p),
    .acc_sub_p(acc_sub_p),
    .acc_load_p(acc_load_p),
    .acc_xor(acc_xor),
    .t_load(t_load),
    .mult_start(mult_start),
    .mult_unsigned(mult_unsigned),
    .data_move(data_move)
  );

  assign dec_valid = valid_r;
  assign dec_op = out_op_r;
  assign dec_word = word_r;
  assign dec_imm = imm_r;
  assign dec_indirect = word_r[7];
  assign dec_addr = word_r[6:0];
  // Pointer load keeps its value low; every other form uses bits 10-8
  assign dec_aux_idx = (out_op_r == adm_pkg::ADM_OP_AUX_PTR_LOAD) ?
                       word_r[2:0] : word_r[10:8];
  assign dec_mode = word_r[1:0];
  assign dec_shift = word_r[11:8];
  assign dec_page = word_r[8:0];
  assign dec_pc_step = step_r;
  assign fwd_valid = fwd_v_r;
  assign fwd_word = fwd_r;
endmodule : adm_decoder
`default_nettype wire

// >>> testbench/adm_decoder_monitor.sv
// Purpose: Port-level checks on the decoder
// Assumes: One clock domain, bound to adm_decoder
// Notes: Operand tracking follows the two-word pairing only
`timescale 1ns/1ps
`default_nettype none
module adm_decoder_monitor (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [15:0] in_word,
  input wire logic in_valid,
  input wire logic dec_valid,
  input wire adm_pkg::adm_op_e dec_op,
  input wire logic [15:0] dec_word,
  input wire logic [15:0] dec_imm,
  input wire logic [6:0] dec_addr,
  input wire logic [1:0] dec_mode,
  input wire logic [1:0] dec_pc_step,
  input wire logic acc_clear,
  input wire logic acc_xor,
  input wire logic fwd_valid,
  input wire logic [15:0] fwd_word
);
  logic pend_r;
  logic pend_nxt;
  logic first_two;
  assign first_two = in_valid && !pend_r &&
    ((in_word[15:12] == 4'hd && in_word[7:0] == 8'h06) ||
     (in_word[15:11] == 5'h1a && in_word[7:0] == 8'h00) ||
     in_word[15:9] == 7'h2e);
  always_comb begin
    pend_nxt = pend_r;
    if (first_two)
      pend_nxt = 1'b1;
    else if (in_valid)
      pend_nxt = 1'b0;
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      pend_r <= 1'b0;
    else
      pend_r <= pend_nxt;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_clear_take;
    in_valid && !pend_r && in_word == adm_pkg::WORD_CLEAR_ACC;
  endsequence
  sequence s_clear_out;
    dec_valid && dec_op == adm_pkg::ADM_OP_CLEAR_ACC && acc_clear &&
      dec_pc_step == 2'h1;
  endsequence
  a_clear_acc_out: assert property (s_clear_take |=> s_clear_out)
    else $error("clear word not decoded one cycle later");
  a_first_word_quiet: assert property (first_two |=>
    !dec_valid && !fwd_valid) else $error("first word acted on");
  a_second_word_imm: assert property (pend_r && in_valid |=>
    dec_valid && dec_pc_step == 2'h2 && dec_imm == $past(in_word))
    else $error("second word not paired");
  a_fwd_copy_word: assert property (fwd_valid |->
    $past(in_valid) && fwd_word == $past(in_word))
    else $error("forwarded word differs");
  a_no_dual_pulse: assert property (!(dec_valid && fwd_valid))
    else $error("decode and forward together");
  a_strobe_quiet: assert property (!dec_valid |->
    !acc_clear && !acc_xor) else $error("strobe without decode");
  a_addr_in_page: assert property (dec_valid |->
    dec_addr == dec_word[6:0]) else $error("address field wrong");
  a_mode_field: assert property (dec_valid &&
    (dec_op == adm_pkg::ADM_OP_AUX_COMPARE ||
     dec_op == adm_pkg::ADM_OP_PRODUCT_SHIFT_SET) |->
    dec_mode == dec_word[1:0]) else $error("mode field wrong");
  a_xor_imm_form: assert property (dec_valid &&
    dec_op == adm_pkg::ADM_OP_XOR_IMM |-> acc_xor &&
    dec_word[15:12] == 4'hd && dec_word[7:0] == 8'h06)
    else $error("xor immediate form wrong");
endmodule : adm_decoder_monitor
bind adm_decoder adm_decoder_monitor adm_decoder_monitor_i (.sys_clk,
  .nrst, .in_word, .in_valid, .dec_valid, .dec_op, .dec_word, .dec_imm,
  .dec_addr, .dec_mode, .dec_pc_step, .acc_clear, .acc_xor, .fwd_valid,
  .fwd_word);
`default_nettype wire

// >>> testbench/adm_fetch_model.sv
// Purpose: Fetch stage offering instruction words
// Assumes: Word taken at a rising edge with ready high
// Notes: Idle bus shows the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module adm_fetch_model (
  input wire logic sys_clk,
  input wire logic in_ready,
  output logic [15:0] in_word,
  output logic in_valid
);
  initial begin
    in_word = 16'h0000;
    in_valid = 1'b0;
  end
  task automatic send(input logic [15:0] w);
    @(posedge sys_clk);
    while (in_valid && !in_ready)
      @(posedge sys_clk);
    in_word <= w;
    in_valid <= 1'b1;
  endtask : send
  // Stale data would hide a decoder reading an idle bus
  task automatic idle();
    @(posedge sys_clk);
    while (in_valid && !in_ready)
      @(posedge sys_clk);
    in_valid <= 1'b0;
    in_word <= ~in_word;
  endtask : idle
endmodule : adm_fetch_model
`default_nettype wire

// >>> testbench/adm_decoder_tb_top.sv
// Purpose: Self-checking bench for the decoder
// Assumes: One-cycle decode latency after the last word
// Notes: Rows follow the operation class order
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); \
  end \
end
module adm_decoder_tb_top;
  localparam logic [15:0] OPERAND = 16'hc35a;
  logic sys_clk, nrst, in_valid, in_ready, dec_valid, fwd_valid;
  logic [15:0] in_word, dec_word, dec_imm, fwd_word;
  logic [2:0] dec_aux_idx;
  logic dec_indirect;
  logic [6:0] dec_addr;
  logic [1:0] dec_mode;
  // Strobes, clear first, data move last; one port drives each bit
  wire logic [11:0] strb;
  logic [3:0] dec_shift;
  logic [8:0] dec_page;
  logic [1:0] dec_pc_step;
  adm_pkg::adm_op_e dec_op;
  adm_pkg::adm_op_e exp_op;
  int miscompares = 0;
  int n_compared = 0;
  logic [15:0] rows [38] = '{
    16'h46a5, 16'h4c12, 16'hd306, 16'hca00, 16'h4081, 16'h7b7f, 16'h4100,
    16'h7e80, 16'hce53, 16'h3501, 16'hc7ff, 16'h558f, 16'h5210, 16'hc9ff,
    16'hd700, 16'h5508, 16'h70c3, 16'hce15, 16'h5302, 16'h3c00, 16'h3d7f,
    16'h3f01, 16'h3e40, 16'h5b22, 16'h5d33, 16'h5c80, 16'h3844, 16'h3a55,
    16'hb000, 16'h3b66, 16'hcf77, 16'hce14, 16'hce16, 16'h7d88, 16'h7c99,
    16'hce0b, 16'h39aa, 16'h5abb};
  // Expected strobes per row: clear, load high, load low, round, add p,
  // sub p, load p, xor, t load, mult, unsigned, move
  logic [11:0] strobes [38] = '{
    12'h000, 12'h010, 12'h010, 12'h800, 12'hc00, 12'hd00, 12'ha00,
    12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000,
    12'h000, 12'h000, 12'h000, 12'h080, 12'h000, 12'h008, 12'h088,
    12'h089, 12'h028, 12'h048, 12'h084, 12'h085, 12'h004, 12'h084,
    12'h004, 12'h044, 12'h006, 12'h020, 12'h040, 12'h000, 12'h000,
    12'h000, 12'h08c, 12'h04c};
  logic [15:0] foreign [4] = '{16'hffff, 16'hd0a6, 16'hce17, 16'hca01};
  adm_fetch_model adm_fetch_model_i (.sys_clk, .in_ready, .in_word,
    .in_valid);
  adm_decoder adm_decoder_i (.sys_clk, .nrst, .in_word, .in_valid,
    .in_ready, .dec_valid, .dec_op, .dec_word, .dec_imm, .dec_indirect,
    .dec_addr, .dec_aux_idx, .dec_mode, .dec_shift, .dec_page,
    .dec_pc_step, .acc_clear(strb[11]), .acc_load_high(strb[10]),
    .acc_load_low_u(strb[9]), .acc_round(strb[8]), .acc_add_p(strb[7]),
    .acc_sub_p(strb[6]), .acc_load_p(strb[5]), .acc_xor(strb[4]),
    .t_load(strb[3]), .mult_start(strb[2]), .mult_unsigned(strb[1]),
    .data_move(strb[0]), .fwd_valid, .fwd_word);
  function automatic logic is_two(input adm_pkg::adm_op_e op);
    return op inside {adm_pkg::ADM_OP_XOR_IMM, adm_pkg::ADM_OP_MAC_PROG,
      adm_pkg::ADM_OP_AUX_LOAD_LONG, adm_pkg::ADM_OP_MAC_SHIFT_DATA};
  endfunction : is_two
  function automatic logic [15:0] exp_imm(input logic [15:0] w,
      input adm_pkg::adm_op_e op);
    if (is_two(op))
      return OPERAND;
    if (op == adm_pkg::ADM_OP_PRODUCT_BY_IMM)
      return {{3{w[12]}}, w[12:0]};
    if (op inside {adm_pkg::ADM_OP_AUX_ADD_SHORT,
        adm_pkg::ADM_OP_AUX_LOAD_SHORT})
      return {8'h00, w[7:0]};
    return 16'h0000;
  endfunction : exp_imm
  task automatic print_verdict();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic expect_dec(input adm_pkg::adm_op_e op,
      input logic [15:0] imm);
    #1;
    `CHK("dec_valid", 1'b1, dec_valid)
    `CHK("dec_op", op, dec_op)
    `CHK("dec_imm", imm, dec_imm)
  endtask : expect_dec
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #(2000 * 40);
    miscompares++;
    print_verdict();
  end
  initial begin
    nrst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("reset dec_valid", 1'b0, dec_valid)
    `CHK("reset fwd_valid", 1'b0, fwd_valid)
    `CHK("reset dec_op", adm_pkg::ADM_OP_NONE, dec_op)
    @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      exp_op = adm_pkg::adm_op_e'(i + 1);
      adm_fetch_model_i.send(rows[i]);
      if (is_two(exp_op))
        adm_fetch_model_i.send(OPERAND);
      adm_fetch_model_i.idle();
      expect_dec(exp_op, exp_imm(rows[i], exp_op));
      `CHK("dec_word", rows[i], dec_word)
      `CHK("pc_step", is_two(exp_op) ? 2'h2 : 2'h1, dec_pc_step)
      `CHK("fwd_valid", 1'b0, fwd_valid)
      `CHK("strobes", strobes[i], strb)
      `CHK("dec_addr", rows[i][6:0], dec_addr)
      `CHK("dec_indirect", rows[i][7], dec_indirect)
      `CHK("dec_mode", rows[i][1:0], dec_mode)
      if (exp_op == adm_pkg::ADM_OP_PAGE_LOAD_SHORT)
        `CHK("dec_page", 9'h1ff, dec_page)
      if (exp_op inside {adm_pkg::ADM_OP_AUX_LOAD_LONG,
          adm_pkg::ADM_OP_AUX_PTR_LOAD})
        `CHK("dec_aux_idx", 3'h7, dec_aux_idx)
    end
    foreach (foreign[i]) begin
      adm_fetch_model_i.send(foreign[i]);
      adm_fetch_model_i.idle();
      #1;
      `CHK("fwd_valid", 1'b1, fwd_valid)
      `CHK("fwd_word", foreign[i], fwd_word)
      `CHK("dec_valid", 1'b0, dec_valid)
      `CHK("fwd strobes", 12'h000, strb)
    end
    // Operand that looks like an opcode, then the same word for real
    adm_fetch_model_i.send(16'h5d12);
    adm_fetch_model_i.send(16'hca00);
    adm_fetch_model_i.send(16'hca00);
    expect_dec(adm_pkg::ADM_OP_MAC_PROG, 16'hca00);
    adm_fetch_model_i.idle();
    expect_dec(adm_pkg::ADM_OP_CLEAR_ACC, 16'h0000);
    // Gap between the two words of the shifted xor
    adm_fetch_model_i.send(16'hd306);
    adm_fetch_model_i.idle();
    adm_fetch_model_i.idle();
    #1;
    `CHK("gap dec_valid", 1'b0, dec_valid)
    adm_fetch_model_i.send(16'h1234);
    adm_fetch_model_i.idle();
    expect_dec(adm_pkg::ADM_OP_XOR_IMM, 16'h1234);
    `CHK("dec_shift", 4'h3, dec_shift)
    // Reset between the words drops the pending operand
    adm_fetch_model_i.send(16'hd200);
    adm_fetch_model_i.idle();
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    adm_fetch_model_i.send(16'hca00);
    adm_fetch_model_i.idle();
    expect_dec(adm_pkg::ADM_OP_CLEAR_ACC, 16'h0000);
    print_verdict();
  end
endmodule : adm_decoder_tb_top
`default_nettype wire
